/* inc/sec_pkg.sv */
// shared constants and types of the serial rom controller
package sec_pkg;
	// ==========================================
	// signature, frame lengths and timing
	localparam logic [7:0] SIG = 8'ha5;
	localparam logic [4:0] SHORT_BITS = 5'h0a;
	localparam logic [4:0] LONG_BITS = 5'h12;
	localparam logic [4:0] DRV_BITS = 5'h0a;
	localparam logic [2:0] ADDR_BYTES = 3'h6;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_KHZ = 25000;
	localparam int TIMEOUT_MS = 30;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int GAP_NS = 250;
	localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = 4;
	// ==========================================
	// host command codes
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROTECT_ON = 3'h1,
		OP_PROTECT_OFF = 3'h2,
		OP_WRITE = 3'h3,
		OP_WRITE_WHOLE = 3'h4,
		OP_ERASE = 3'h5,
		OP_ERASE_WHOLE = 3'h6,
		OP_RELOAD = 3'h7
	} sec_op_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_XFER = 4'h2,
		ST_GAP = 4'h4,
		ST_POLL = 4'h8
	} sec_st_t;
	// ==========================================
	// serial frame
	typedef struct packed {
		logic [4:0] nb;
		logic [17:0] tx;
		logic rd;
	} sec_frame_t;
	// start bit, opcode, address, data
	function automatic sec_frame_t sec_frame(sec_op_t op, logic [6:0] adr, logic [7:0] dat);
		sec_frame_t f;
		f.nb = SHORT_BITS; // R17
		f.rd = 1'b0;
		f.tx = {1'b1, 2'b00, 7'h00, 8'h00}; // R15
		case (op)
			OP_READ, OP_RELOAD: begin
				f = '{nb: LONG_BITS, tx: {1'b1, 2'b10, adr, 8'h00}, rd: 1'b1}; // R18
			end
			OP_WRITE: f.tx = {1'b1, 2'b01, adr, dat}; // R14
			OP_WRITE_WHOLE: f.tx = {1'b1, 2'b00, 7'h20, dat}; // R14
			OP_ERASE: f.tx = {1'b1, 2'b11, adr, 8'h00}; // R13
			OP_ERASE_WHOLE: f.tx = {1'b1, 2'b00, 7'h40, 8'h00}; // R13
			OP_PROTECT_OFF: f.tx = {1'b1, 2'b00, 7'h60, 8'h00}; // R15
			default: f.tx = {1'b1, 2'b00, 7'h00, 8'h00};
		endcase
		if (op == OP_WRITE || op == OP_WRITE_WHOLE) begin
			f.nb = LONG_BITS; // R17
		end
		return f;
	endfunction
	// ==========================================
	// state records
	typedef struct packed {
		sec_st_t st;
		logic busy;
		logic to;
		logic loaded;
		logic rel_ok;
		sec_op_t op;
		logic [6:0] adr;
		logic [7:0] data;
		logic [47:0] sta;
		logic sta_load;
		logic ld;
		logic rel;
		logic [2:0] idx;
		logic [19:0] cnt;
		logic start;
		sec_frame_t fr;
		logic d1;
		logic d2;
		logic cs;
		logic sck;
		logic dout;
		logic oe_n;
	} sec_ctl_t;
	typedef struct packed {
		logic busy;
		logic cs;
		logic sck;
		logic [7:0] div;
		logic [4:0] idx;
		logic [17:0] sh;
		logic [7:0] rx;
		logic done;
	} sec_eng_t;
	localparam sec_ctl_t CTL_RST = '{st: ST_IDLE, op: OP_READ, busy: 1'b1, ld: 1'b1,
		oe_n: 1'b1, default: '0};
	localparam sec_eng_t ENG_RST = '0;
endpackage

/* inc/sec_if.sv */
// link between the command sequencer and the serial shifter
`timescale 1ns/10ps
`default_nettype none
interface sec_if;
	logic start;
	logic kill;
	logic [4:0] nb;
	logic [17:0] tx;
	logic rd;
	logic din;
	logic done;
	logic [7:0] rx;
	logic cs;
	logic sclk;
	logic di;
	logic drv;
	modport ctl (output start, kill, nb, tx, rd, din, input done, rx, cs, sclk, di, drv);
	modport eng (input start, kill, nb, tx, rd, din, output done, rx, cs, sclk, di, drv);
endinterface
`default_nettype wire

/* rtl/sec_shift.sv */
// serial shifter: makes the rom clock and moves one frame
`timescale 1ns/10ps
`default_nettype none
module sec_shift #(
	parameter int CLK_HALF = sec_pkg::SCLK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	sec_if.eng io
);
	if (CLK_HALF < 4 || CLK_HALF > 256) begin : g_chk
		$error("sec_shift: CLK_HALF must be 4 to 256");
	end
	sec_pkg::sec_eng_t s;
	sec_pkg::sec_eng_t next_s;
	// ==========================================
	// shifter
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (io.kill) begin
			next_s = sec_pkg::ENG_RST;
		end else if (!s.busy) begin
			if (io.start) begin
				next_s.busy = 1'b1;
				next_s.cs = 1'b1; // R20
				next_s.sh = io.tx;
				next_s.idx = 5'h00;
				next_s.div = 8'h00;
				next_s.sck = 1'b0;
			end
		end else if (s.div == 8'(CLK_HALF - 1)) begin
			next_s.div = 8'h00;
			next_s.sck = !s.sck;
			if (s.sck) begin
				next_s.rx = {s.rx[6:0], io.din};
				next_s.sh = {s.sh[16:0], 1'b0};
				next_s.idx = s.idx + 5'h01;
				if (s.idx == io.nb - 5'h01) begin // R17
					next_s.busy = 1'b0;
					next_s.cs = 1'b0; // R20
					next_s.done = 1'b1;
				end
			end
		end else begin
			next_s.div = s.div + 8'h01;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= sec_pkg::ENG_RST;
		end else if (clk_en) begin
			s <= next_s;
		end
	end
	assign io.cs = s.cs;
	assign io.sclk = s.sck;
	assign io.di = s.sh[17];
	assign io.done = s.done;
	assign io.rx = s.rx;
	assign io.drv = s.idx < sec_pkg::DRV_BITS || !io.rd;
	// ==========================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst || !clk_en || io.kill);
	sequence sq_launch;
		io.start && !s.busy;
	endsequence
	property p_start_bit;
		sq_launch |=> s.cs && io.di && !s.sck;
	endproperty
	a_start_bit: assert property (p_start_bit) // R20
		else $error("frame does not open with select and start bit");
	property p_clk_count;
		$fell(s.busy) && !$past(io.kill) |-> s.idx == io.nb && !s.cs && s.done;
	endproperty
	a_clk_count: assert property (p_clk_count) // R17
		else $error("frame ended after wrong number of clocks");
endmodule
`default_nettype wire

/* rtl/sec_ctl.sv */
// serial rom controller: address auto-load and host commands
// Operation
// R1: check byte 00h for signature a5h
// R2: copy next six bytes into station address
// R3: set loaded flag after six bytes
// R4: missing signature leaves station address untouched
// R5: reload command repeats check, fails without signature
// R6: success bit only after good reload
// R7: host waits for auto-load to finish
// R8: host loads data before write commands
// R9: busy set starts command, clears when done
// R10: read byte ready when busy clears
// R11: host leaves command alone while busy
// R12: 30 ms without answer sets timeout
// R13: erase one or all when enabled
// R14: write one or all from data
// R15: protect on and off commands
// R16: host enables writes before modifying
// R17: 10 or 18 clocks per frame
// R18: 128 locations of eight bits
// R19: disabled interface hands pins to general outputs
// R20: select, start, opcode, address, data, deselect
`timescale 1ns/10ps
`default_nettype none
module sec_ctl #(
	parameter int TIMEOUT_CYC = sec_pkg::TIMEOUT_CYC,
	parameter int CLK_HALF = sec_pkg::SCLK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic soft_reset,
	input wire logic cmd_wr,
	input wire logic [2:0] cmd_op,
	input wire logic [6:0] cmd_addr,
	input wire logic cmd_go,
	input wire logic to_clr,
	input wire logic data_wr,
	input wire logic [7:0] data_in,
	input wire logic if_off,
	input wire logic gpo_clk,
	input wire logic gpo_dio,
	input wire logic rom_serial_data_pin_in,
	output logic [2:0] rom_opcode_field,
	output logic [6:0] rom_location_field,
	output logic rom_busy_bit,
	output logic rom_timeout_flag,
	output logic addr_loaded_bit,
	output logic reload_success_bit,
	output logic [7:0] rom_data_register,
	output logic [31:0] station_address_low,
	output logic [15:0] station_address_high,
	output logic station_address_load,
	output logic rom_cs,
	output logic rom_serial_clock_pin,
	output logic rom_serial_data_pin_out,
	output logic rom_serial_data_pin_oe_n
);
	if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= 2 ** 20) begin : g_chk
		$error("sec_ctl: TIMEOUT_CYC out of range");
	end
	localparam logic [19:0] TO_LAST = 20'(TIMEOUT_CYC - 1);
	localparam logic [19:0] GAP_LAST = 20'(sec_pkg::GAP_CYC - 1);
	sec_pkg::sec_ctl_t s;
	sec_pkg::sec_ctl_t next_s;
	sec_if io ();
	sec_shift #(
		.CLK_HALF(CLK_HALF)
	) sec_shift_inst (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.io(io)
	);
	assign io.start = s.start;
	assign io.kill = soft_reset;
	assign io.nb = s.fr.nb;
	assign io.tx = s.fr.tx;
	assign io.rd = s.fr.rd;
	assign io.din = s.d2;
	// ==========================================
	// sequencer
	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.sta_load = 1'b0;
		next_s.d1 = rom_serial_data_pin_in;
		next_s.d2 = s.d1;
		if (to_clr) begin
			next_s.to = 1'b0;
		end
		case (s.st)
			sec_pkg::ST_IDLE: begin
				if (s.busy) begin
					if (s.ld) begin
						next_s.fr = sec_pkg::sec_frame(sec_pkg::OP_READ, {4'h0, s.idx}, 8'h00); // R1
					end else begin
						next_s.fr = sec_pkg::sec_frame(s.op, s.adr, s.data);
					end
					next_s.start = 1'b1; // R9
					next_s.st = sec_pkg::ST_XFER;
				end else begin
					if (cmd_wr) begin // R11
						next_s.op = sec_pkg::sec_op_t'(cmd_op);
						next_s.adr = cmd_addr; // R18
						if (cmd_go) begin
							next_s.busy = 1'b1; // R9
							if (sec_pkg::sec_op_t'(cmd_op) == sec_pkg::OP_RELOAD) begin
								next_s.ld = 1'b1; // R5
								next_s.rel = 1'b1;
								next_s.idx = 3'h0;
								next_s.rel_ok = 1'b0;
							end
						end
					end
					if (data_wr) begin // R8
						next_s.data = data_in;
					end
				end
			end
			sec_pkg::ST_XFER: begin
				if (io.done) begin
					next_s.st = sec_pkg::ST_IDLE;
					if (s.ld) begin
						if (s.idx == 3'h0) begin
							if (io.rx == sec_pkg::SIG) begin // R1
								next_s.idx = 3'h1;
							end else begin
								next_s.busy = 1'b0; // R4
								next_s.ld = 1'b0;
								next_s.rel = 1'b0; // R5
							end
						end else begin
							next_s.sta[{3'(s.idx - 3'h1), 3'b000} +: 8] = io.rx; // R2
							next_s.idx = s.idx + 3'h1;
							if (s.idx == sec_pkg::ADDR_BYTES) begin
								next_s.loaded = 1'b1; // R3
								next_s.rel_ok = s.rel; // R6
								next_s.sta_load = 1'b1;
								next_s.busy = 1'b0;
								next_s.ld = 1'b0;
								next_s.rel = 1'b0;
							end
						end
					end else begin
						case (s.op)
							sec_pkg::OP_READ: begin
								next_s.data = io.rx; // R10
								next_s.busy = 1'b0;
							end
							sec_pkg::OP_WRITE, sec_pkg::OP_WRITE_WHOLE, // R14
							sec_pkg::OP_ERASE, sec_pkg::OP_ERASE_WHOLE: begin
								next_s.st = sec_pkg::ST_GAP; // R13
								next_s.cnt = 20'h00000;
							end
							default: begin
								next_s.busy = 1'b0; // R15
							end
						endcase
					end
				end
			end
			sec_pkg::ST_GAP: begin
				next_s.cnt = s.cnt + 20'h00001;
				if (s.cnt == GAP_LAST) begin
					next_s.st = sec_pkg::ST_POLL;
					next_s.cnt = 20'h00000;
				end
			end
			sec_pkg::ST_POLL: begin
				next_s.cnt = s.cnt + 20'h00001;
				if (s.d2) begin
					next_s.busy = 1'b0; // R9
					next_s.st = sec_pkg::ST_IDLE;
				end else if (s.cnt == TO_LAST) begin
					next_s.to = 1'b1; // R12
					next_s.busy = 1'b0; // R12
					next_s.st = sec_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.st = sec_pkg::ST_IDLE;
			end
		endcase
		// pin stage
		if (if_off) begin
			next_s.cs = 1'b0; // R19
			next_s.sck = gpo_clk; // R19
			next_s.dout = gpo_dio; // R19
			next_s.oe_n = 1'b0; // R19
		end else begin
			next_s.cs = io.cs || s.st == sec_pkg::ST_POLL; // R20
			next_s.sck = io.sclk;
			next_s.dout = io.di;
			next_s.oe_n = !(io.cs && io.drv);
		end
		if (soft_reset) begin
			next_s = sec_pkg::CTL_RST; // R1
			next_s.sta = s.sta;
			next_s.d1 = rom_serial_data_pin_in;
			next_s.d2 = s.d1;
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= sec_pkg::CTL_RST;
		end else if (clk_en) begin
			s <= next_s;
		end
	end
	// ==========================================
	// outputs
	assign rom_opcode_field = s.op;
	assign rom_location_field = s.adr;
	assign rom_busy_bit = s.busy;
	assign rom_timeout_flag = s.to;
	assign addr_loaded_bit = s.loaded;
	assign reload_success_bit = s.rel_ok;
	assign rom_data_register = s.data;
	assign station_address_low = s.sta[31:0];
	assign station_address_high = s.sta[47:32];
	assign station_address_load = s.sta_load;
	assign rom_cs = s.cs;
	assign rom_serial_clock_pin = s.sck;
	assign rom_serial_data_pin_out = s.dout;
	assign rom_serial_data_pin_oe_n = s.oe_n;
	// ==========================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst || !clk_en || soft_reset);
	sequence sq_ld_done(logic [2:0] n);
		s.st == sec_pkg::ST_XFER && io.done && s.ld && s.idx == n;
	endsequence
	sequence sq_go;
		s.st == sec_pkg::ST_IDLE && !s.busy && cmd_wr && cmd_go;
	endsequence
	property p_sig_addr;
		io.start && s.ld && s.idx == 3'h0 |-> s.fr.tx[16:8] == 9'h100 && s.fr.nb == 5'h12;
	endproperty
	a_sig_addr: assert property (p_sig_addr) // R1
		else $error("signature fetch not a read of location 0");
	property p_first_byte;
		sq_ld_done(3'h1) |=> s.sta[7:0] == $past(io.rx) && s.idx == 3'h2;
	endproperty
	a_first_byte: assert property (p_first_byte) // R2
		else $error("first address byte not in byte 0");
	property p_loaded;
		sq_ld_done(3'h6) |=> addr_loaded_bit && !rom_busy_bit && station_address_load;
	endproperty
	a_loaded: assert property (p_loaded) // R3
		else $error("loaded flag not set after six bytes");
	property p_no_sig;
		sq_ld_done(3'h0) ##0 io.rx != 8'ha5 |=> !rom_busy_bit && $stable(s.sta) && !s.ld;
	endproperty
	a_no_sig: assert property (p_no_sig) // R4
		else $error("missing signature did not end load cleanly");
	property p_rel_ok;
		$rose(reload_success_bit) |-> $past(s.rel) && addr_loaded_bit;
	endproperty
	a_rel_ok: assert property (p_rel_ok) // R6
		else $error("success bit set without a reload");
	property p_go;
		sq_go |=> rom_busy_bit ##1 io.start;
	endproperty
	a_go: assert property (p_go) // R9
		else $error("busy set did not launch the command");
	property p_read;
		s.st == sec_pkg::ST_XFER && io.done && !s.ld && s.op == sec_pkg::OP_READ
			|=> rom_data_register == $past(io.rx) && !rom_busy_bit;
	endproperty
	a_read: assert property (p_read) // R10
		else $error("read data not in data register when busy clears");
	property p_timeout;
		s.st == sec_pkg::ST_POLL && !s.d2 && s.cnt == TO_LAST |=> rom_timeout_flag && !rom_busy_bit;
	endproperty
	a_timeout: assert property (p_timeout) // R12
		else $error("timeout did not abandon the operation");
	property p_gpio;
		if_off |=> !rom_cs && rom_serial_clock_pin == $past(gpo_clk)
			&& rom_serial_data_pin_out == $past(gpo_dio) && !rom_serial_data_pin_oe_n;
	endproperty
	a_gpio: assert property (p_gpio) // R19
		else $error("disabled interface does not pass general outputs");
endmodule
`default_nettype wire

/* tb/sec_rom.sv */
// behavioural serial rom on the far side of the link
`timescale 1ns/10ps
`default_nettype none
module sec_rom (
	input wire logic cs,
	input wire logic sck,
	input wire logic di,
	input wire logic hang,
	input wire logic slow,
	output logic q
);
	// ====
	// storage, frame decode, ready poll
	logic [7:0] mem [128];
	logic [17:0] sh;
	logic [9:0] c;
	logic wen;
	logic pend;
	int n;
	initial begin
		q = 1'b0;
		wen = 1'b0;
		pend = 1'b0;
		n = 0;
	end
	always @(posedge cs) begin
		n = 0;
		if (pend) begin
			q = 1'b0;
			if (!hang) begin
				if (wen) #(slow ? 4000 : 200);
				q = 1'b1;
			end
		end
	end
	always @(posedge sck) begin
		if (cs) begin
			n = n + 1;
			sh = {sh[16:0], di};
			if (n == 10) c = sh[9:0];
		end
	end
	always @(negedge sck) begin
		if (cs && n >= 10 && n < 18 && c[8:7] == 2'b10) q = mem[c[6:0]][17 - n];
	end
	always @(negedge cs) begin
		if (pend) begin
			pend = 1'b0;
		end else if (n == 10 || n == 18) begin
			case (c[8:7])
				2'b01: if (wen) mem[c[6:0]] = sh[7:0];
				2'b11: if (wen) mem[c[6:0]] = 8'hff;
				2'b00: case (c[6:5])
					2'b11: wen = 1'b1;
					2'b00: wen = 1'b0;
					2'b10: if (wen) for (int i = 0; i < 128; i++) mem[i] = 8'hff;
					default: if (wen) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
				endcase
				default: ;
			endcase
			pend = c[8:7] != 2'b10 && !(c[8:7] == 2'b00 && c[6] == c[5]);
		end
		q = pend ? 1'b0 : ~q;
	end
endmodule
`default_nettype wire

/* tb/tb_sec_ctl.sv */
// queue-checked bench of the serial rom controller
`timescale 1ns/10ps
`default_nettype none
module tb_sec_ctl;
	// ====
	// signals
	typedef struct packed {
		logic [47:0] sta;
		logic [7:0] d;
		logic to;
		logic ok;
		logic ld;
		logic [4:0] nb;
		logic cd;
	} sec_exp_t;
	logic core_clk, rst, soft_reset, cmd_wr, cmd_go, to_clr, data_wr, if_off, gpo_clk, gpo_dio;
	logic [2:0] cmd_op, opf;
	logic [6:0] locf;
	int loads;
	logic [6:0] cmd_addr, a;
	logic [7:0] data_in, rom_data_register, b;
	logic rom_busy_bit, rom_timeout_flag, addr_loaded_bit, reload_success_bit;
	logic [31:0] station_address_low;
	logic [15:0] station_address_high;
	logic rom_cs, rom_serial_clock_pin, rom_serial_data_pin_out, rom_serial_data_pin_oe_n;
	logic q, hang, slow, exp_to, exp_ok, exp_ld, was_busy, ld_pulse;
	logic [47:0] exp_sta;
	logic [4:0] cnt, last_nb;
	logic [31:0] lf = 32'h1a2ad428;
	int err_count, checked, cycles;
	sec_exp_t expq[$];
	sec_exp_t e, s;
	wire logic din = rom_serial_data_pin_oe_n ? q : rom_serial_data_pin_out;
	sec_ctl #(.TIMEOUT_CYC(200)) sec_ctl_inst (.core_clk, .rst, .clk_en(1'b1), .soft_reset,
		.cmd_wr, .cmd_op, .cmd_addr, .cmd_go, .to_clr, .data_wr, .data_in, .if_off, .gpo_clk,
		.gpo_dio, .rom_serial_data_pin_in(din), .rom_opcode_field(opf), .rom_location_field(locf),
		.rom_busy_bit, .rom_timeout_flag, .addr_loaded_bit, .reload_success_bit,
		.rom_data_register, .station_address_low, .station_address_high,
		.station_address_load(ld_pulse), .rom_cs, .rom_serial_clock_pin, .rom_serial_data_pin_out,
		.rom_serial_data_pin_oe_n);
	sec_rom sec_rom_inst (.cs(rom_cs), .sck(rom_serial_clock_pin), .di(rom_serial_data_pin_out),
		.hang, .slow, .q);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ====
	// helpers
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04c11db7 : 32'h00000000);
		return lf;
	endfunction
	task automatic check(input logic [64:0] sv, input logic [64:0] ev);
		checked++;
		if (sv !== ev) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, sv, ev);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic load_rom(input logic [7:0] sig);
		sec_rom_inst.mem[0] = sig;
		for (int i = 127; i > 0; i--) begin
			sec_rom_inst.mem[i] = 8'(rnd());
			if (i < 7 && sig == sec_pkg::SIG) exp_sta = {exp_sta[39:0], sec_rom_inst.mem[i]};
		end
	endtask
	task automatic wait_idle;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 3000 && rom_busy_bit !== 1'b0; i++) @(posedge core_clk);
		if (rom_busy_bit !== 1'b0) err_count++;
		@(posedge core_clk);
	endtask
	task automatic run(input logic [2:0] op, input logic [6:0] ad, input logic [7:0] d,
		input logic [7:0] rd, input logic cd);
		expq.push_back('{exp_sta, rd, exp_to, exp_ok, exp_ld,
			(op inside {3'h1, 3'h2, 3'h5, 3'h6}) ? sec_pkg::SHORT_BITS : sec_pkg::LONG_BITS, cd});
		@(posedge core_clk);
		#1 {cmd_wr, cmd_go, data_wr, cmd_op, cmd_addr, data_in} = {3'b111, op, ad, d};
		@(posedge core_clk);
		#1 {cmd_wr, cmd_go, data_wr} = 3'b000;
		wait_idle();
		check(65'({opf, locf}), 65'({op, ad}));
	endtask
	task automatic rw(input logic [2:0] op, input logic [6:0] ad, input logic [7:0] d,
		input logic [7:0] bk);
		run(op, ad, d, d, 1'b1);
		run(3'h0, ad, ~d, bk, 1'b1);
	endtask
	// ====
	// result watcher and watchdog
	always @(posedge rom_serial_clock_pin) if (rom_cs) cnt = cnt + 5'h01;
	always @(negedge rom_cs) begin
		if (cnt != 5'h00) last_nb = cnt;
		cnt = 5'h00;
	end
	always @(negedge core_clk) begin
		if (was_busy === 1'b1 && rom_busy_bit === 1'b0) begin
			e = expq.pop_front();
			s = {station_address_high, station_address_low, rom_data_register, rom_timeout_flag,
				reload_success_bit, addr_loaded_bit, last_nb, e.cd};
			if (!e.cd) s.d = e.d;
			check(s, e);
		end
		was_busy = rom_busy_bit;
	end
	always @(posedge core_clk) begin
		if (ld_pulse === 1'b1) loads++;
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			print_verdict();
		end
	end
	// ====
	// main sequence
	initial begin
		{rst, soft_reset, cmd_wr, cmd_go, to_clr, data_wr, if_off, gpo_clk, gpo_dio} = 9'h100;
		{hang, slow, cmd_op, cmd_addr, data_in, exp_to, exp_ok, was_busy, cnt, last_nb} = '0;
		load_rom(sec_pkg::SIG);
		exp_ld = 1'b1;
		expq.push_back('{exp_sta, 8'h00, 1'b0, 1'b0, 1'b1, sec_pkg::LONG_BITS, 1'b0});
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		wait_idle();
		$display("test autoload done");
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 7'h7f : 7'(rnd());
			run(3'h0, a, 8'(rnd()), sec_rom_inst.mem[a], 1'b1);
		end
		$display("test read done");
		a = 7'(rnd());
		b = sec_rom_inst.mem[a];
		rw(3'h3, a, 8'h5a, b);
		run(3'h2, a, 8'h11, 8'h11, 1'b1);
		slow = 1'b1;
		rw(3'h3, a, 8'h5a, 8'h5a);
		slow = 1'b0;
		rw(3'h5, a, 8'h22, 8'hff);
		rw(3'h4, 7'h00, 8'h96, 8'h96);
		rw(3'h6, 7'h7f, 8'h33, 8'hff);
		run(3'h1, a, 8'h44, 8'h44, 1'b1);
		rw(3'h3, a, 8'h69, 8'hff);
		$display("test program done");
		hang = 1'b1;
		exp_to = 1'b1;
		run(3'h3, a, 8'h77, 8'h77, 1'b1);
		hang = 1'b0;
		#1 to_clr = 1'b1;
		@(posedge core_clk);
		#1 to_clr = 1'b0;
		exp_to = 1'b0;
		$display("test timeout done");
		load_rom(sec_pkg::SIG);
		exp_ok = 1'b1;
		run(3'h7, 7'h00, 8'h00, 8'h00, 1'b0);
		load_rom(8'h5a);
		exp_ok = 1'b0;
		run(3'h7, 7'h00, 8'h00, 8'h00, 1'b0);
		exp_ld = 1'b0;
		expq.push_back('{exp_sta, 8'h00, 1'b0, 1'b0, 1'b0, sec_pkg::LONG_BITS, 1'b0});
		#1 soft_reset = 1'b1;
		@(posedge core_clk);
		#1 soft_reset = 1'b0;
		wait_idle();
		$display("test reload done");
		#1 if_off = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{gpo_clk, gpo_dio} = 2'(rnd());
			repeat (3) @(posedge core_clk);
			#1 check(65'({rom_serial_clock_pin, rom_serial_data_pin_out}), 65'({gpo_clk, gpo_dio}));
		end
		$display("test pins done");
		check(65'(loads), 65'd2);
		print_verdict();
	end
endmodule
`default_nettype wire
